/* File: core/eprom_pv_pkg.sv */
// Constants for the EPROM program and verify port.
// Assumes one device clock that also times the serial mode code.
package eprom_pv_pkg;
    // ----------------------------------------
    // Array geometry
    // ----------------------------------------
    localparam int ADDR_W = 11;
    localparam int HI_W = 3;
    localparam int DATA_W = 8;
    localparam int DEPTH = 2048;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // ----------------------------------------
    // Serial mode codes
    // ----------------------------------------
    localparam int CODE_W = 10;
    localparam logic [9:0] CODE_USER = 10'h286;
    localparam logic [9:0] CODE_SIGNATURE = 10'h280;
    // ----------------------------------------
    // Timing, in device clock periods, machine cycles and pulses
    // ----------------------------------------
    localparam int CLK_PER_MACHINE = 12;
    localparam int PRE_HIGH_MACHINE = 2;
    localparam int PRE_HIGH_CLK = PRE_HIGH_MACHINE * CLK_PER_MACHINE;
    localparam int ADDR_SETTLE_CLK = 13;
    localparam int VERIFY_MACHINE = 4;
    localparam int VERIFY_CLK = VERIFY_MACHINE * CLK_PER_MACHINE;
    localparam int PULSES_PER_BYTE = 25;
    localparam int CNT_W = 6;
    // ----------------------------------------
    // Signature locations
    // ----------------------------------------
    localparam logic [10:0] SIG_ADDR0 = 11'h030;
    localparam logic [10:0] SIG_ADDR1 = 11'h031;
    // ----------------------------------------
    // Port state
    // ----------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_PRE = 7'h02,
        ST_ARMED = 7'h04,
        ST_SHIFT = 7'h08,
        ST_USER = 7'h10,
        ST_SIG = 7'h20,
        ST_NONE = 7'h40
    } pv_state_e;
endpackage : eprom_pv_pkg

/* File: core/eprom_program_verify_port.sv */
// Program and verify port of the on-chip program EPROM.
// Assumes CLK_SYS is the crystal clock and all pins are synchronous to it.
`timescale 1ns/1ps
module eprom_program_verify_port #(
    parameter int ADDR_SETTLE = eprom_pv_pkg::ADDR_SETTLE_CLK,
    parameter int VERIFY_DELAY = eprom_pv_pkg::VERIFY_CLK,
    parameter int PULSES = eprom_pv_pkg::PULSES_PER_BYTE,
    parameter logic [7:0] SIG_BYTE0 = 8'h5a, // Arbitrary value
    parameter logic [7:0] SIG_BYTE1 = 8'ha5 // Arbitrary value
) (
    input wire logic CLK_SYS, // Crystal clock
    input wire logic RESET, // Async reset, high
    input wire logic MODE_SERIAL_PIN, // Reset pin as serial code input
    input wire logic ADDRESS_HALF_SELECT, // High part select strobe
    input wire logic [7:0] ADDRESS_INPUT_PORT, // Multiplexed address
    input wire logic PORT0_BIT0_PIN, // Supply pin logic level
    input wire logic PROGRAM_PULSE_STROBE_VOLTAGE_SENSE, // High programming voltage present
    input wire logic PORT0_BIT1_PIN, // Program pulse strobe
    input wire logic [7:0] PROGRAM_DATA_PORT_IN, // Data port input
    output logic [7:0] PROGRAM_DATA_PORT_OUT, // Data port output
    output logic PROGRAM_DATA_PORT_OE, // Data port drive enable
    output logic [10:0] EPROM_ADDRESS, // Internal address
    output logic USER_MODE, // User array mode active
    output logic SIGNATURE_MODE // Signature mode active
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    eprom_pv_pkg::pv_state_e state_ff, nxt_state;
    logic [5:0] pre_cnt_ff, nxt_pre_cnt;
    logic [3:0] bit_cnt_ff;
    logic [9:0] code_ff;
    logic address_half_select_q_ff;
    logic [2:0] hi_addr_ff;
    logic [7:0] lo_seen_ff;
    logic [5:0] settle_cnt_ff;
    logic [10:0] addr_ff;
    logic strobe_q_ff;
    logic [5:0] pulse_cnt_ff;
    logic [5:0] ver_cnt_ff;
    logic [5:0] ver_run_ff;
    logic [7:0] data_ff;
    logic oe_ff;
    logic [7:0] mem [eprom_pv_pkg::DEPTH];

    wire in_mode = (state_ff == eprom_pv_pkg::ST_USER) || (state_ff == eprom_pv_pkg::ST_SIG);
    wire address_half_select_fall = address_half_select_q_ff && !ADDRESS_HALF_SELECT;
    wire lo_changed = (ADDRESS_INPUT_PORT != lo_seen_ff);
    wire settle_done = (settle_cnt_ff == 6'(ADDR_SETTLE - 1));
    wire program_pulse_strobe_level = PROGRAM_PULSE_STROBE_VOLTAGE_SENSE;
    wire verify_level = PORT0_BIT0_PIN && !PROGRAM_PULSE_STROBE_VOLTAGE_SENSE;
    wire strobe_rise = !strobe_q_ff && PORT0_BIT1_PIN;
    wire write_byte = (state_ff == eprom_pv_pkg::ST_USER) && program_pulse_strobe_level && strobe_rise
                      && (pulse_cnt_ff == 6'(PULSES - 1));
    wire [9:0] code_full = {MODE_SERIAL_PIN, code_ff[9:1]};
    wire last_bit = (bit_cnt_ff == 4'(eprom_pv_pkg::CODE_W - 1));
    wire ver_done = (ver_cnt_ff == 6'(VERIFY_DELAY - 2));
    wire sig_hit0 = (addr_ff == eprom_pv_pkg::SIG_ADDR0);
    wire sig_hit1 = (addr_ff == eprom_pv_pkg::SIG_ADDR1);
    wire [7:0] sig_byte = sig_hit0 ? SIG_BYTE0 : (sig_hit1 ? SIG_BYTE1 : eprom_pv_pkg::ERASED_BYTE);
    wire [7:0] read_byte = (state_ff == eprom_pv_pkg::ST_SIG) ? sig_byte : mem[addr_ff];

    // ----------------------------------------
    // Mode entry sequencer
    // ----------------------------------------
    // Next state; a high reset pin restarts entry from idle, user, signature or none
    always_comb begin
        nxt_state = state_ff;
        nxt_pre_cnt = pre_cnt_ff;
        case (state_ff)
            eprom_pv_pkg::ST_IDLE, eprom_pv_pkg::ST_USER, eprom_pv_pkg::ST_SIG,
            eprom_pv_pkg::ST_NONE: begin
                nxt_pre_cnt = '0;
                if (MODE_SERIAL_PIN) begin
                    nxt_state = eprom_pv_pkg::ST_PRE;
                end
            end
            eprom_pv_pkg::ST_PRE: begin
                if (!MODE_SERIAL_PIN) begin
                    nxt_state = eprom_pv_pkg::ST_IDLE;
                end else if (pre_cnt_ff == 6'(eprom_pv_pkg::PRE_HIGH_CLK - 2)) begin
                    nxt_state = eprom_pv_pkg::ST_ARMED;
                end else begin
                    nxt_pre_cnt = pre_cnt_ff + 6'h01;
                end
            end
            // first low is code bit zero
            eprom_pv_pkg::ST_ARMED: begin
                if (!MODE_SERIAL_PIN) begin
                    nxt_state = eprom_pv_pkg::ST_SHIFT;
                end
            end
            eprom_pv_pkg::ST_SHIFT: begin
                if (last_bit) begin
                    if (code_full == eprom_pv_pkg::CODE_USER) begin
                        nxt_state = eprom_pv_pkg::ST_USER;
                    end else if (code_full == eprom_pv_pkg::CODE_SIGNATURE) begin
                        nxt_state = eprom_pv_pkg::ST_SIG;
                    end else begin
                        nxt_state = eprom_pv_pkg::ST_NONE;
                    end
                end
            end
            default: begin
                nxt_state = eprom_pv_pkg::ST_IDLE;
            end
        endcase
    end

    // State and pre-high counter
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            state_ff <= eprom_pv_pkg::ST_IDLE;
            pre_cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            pre_cnt_ff <= nxt_pre_cnt;
        end
    end

    // one bit per rising edge, LSB first
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            code_ff <= '0;
            bit_cnt_ff <= '0;
        end else if (state_ff == eprom_pv_pkg::ST_ARMED || state_ff == eprom_pv_pkg::ST_SHIFT) begin
            // sampled on the clock high edge
            if (state_ff == eprom_pv_pkg::ST_SHIFT || !MODE_SERIAL_PIN) begin
                code_ff <= code_full;
                bit_cnt_ff <= (state_ff == eprom_pv_pkg::ST_SHIFT) ? bit_cnt_ff + 4'h1 : 4'h1;
            end
        end else begin
            bit_cnt_ff <= '0;
        end
    end

    // ----------------------------------------
    // Address multiplexing
    // ----------------------------------------
    // latch high part on falling select
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            address_half_select_q_ff <= 1'b0;
            hi_addr_ff <= '0;
        end else begin
            address_half_select_q_ff <= ADDRESS_HALF_SELECT;
            if (address_half_select_fall) begin
                hi_addr_ff <= ADDRESS_INPUT_PORT[eprom_pv_pkg::HI_W-1:0];
            end
        end
    end

    // commit after low byte settles
    // Settling also swallows the high part lingering after the strobe falls.
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            lo_seen_ff <= '0;
            settle_cnt_ff <= '0;
            addr_ff <= '0;
        end else begin
            lo_seen_ff <= ADDRESS_INPUT_PORT;
            if (ADDRESS_HALF_SELECT || lo_changed) begin
                settle_cnt_ff <= '0;
            end else if (!settle_done) begin
                settle_cnt_ff <= settle_cnt_ff + 6'h01;
            end else begin
                addr_ff <= {hi_addr_ff, lo_seen_ff};
            end
        end
    end

    // ----------------------------------------
    // Programming
    // ----------------------------------------
    // Array starts erased; contents are data, not control state
    initial begin
        for (int i = 0; i < eprom_pv_pkg::DEPTH; i++) begin
            mem[i] = eprom_pv_pkg::ERASED_BYTE;
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            strobe_q_ff <= 1'b1;
            pulse_cnt_ff <= '0;
        end else begin
            strobe_q_ff <= PORT0_BIT1_PIN;
            if (!program_pulse_strobe_level || state_ff != eprom_pv_pkg::ST_USER || write_byte) begin
                pulse_cnt_ff <= '0;
            end else if (strobe_rise) begin
                pulse_cnt_ff <= pulse_cnt_ff + 6'h01;
            end
        end
    end

    // byte taken from the data port
    // Cells only lose ones, as a real EPROM cell would.
    always_ff @(posedge CLK_SYS) begin
        if (write_byte) begin
            mem[addr_ff] <= mem[addr_ff] & PROGRAM_DATA_PORT_IN;
        end
    end

    // ----------------------------------------
    // Verify output
    // ----------------------------------------
    // delay from voltage return to drive
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            ver_cnt_ff <= '0;
            oe_ff <= 1'b0;
            data_ff <= '0;
        end else begin
            data_ff <= read_byte;
            if (!in_mode || !verify_level) begin
                ver_cnt_ff <= '0;
                oe_ff <= 1'b0;
            end else if (!ver_done) begin
                ver_cnt_ff <= ver_cnt_ff + 6'h01;
            end else begin
                oe_ff <= 1'b1;
            end
        end
    end

    // run length of the verify condition
    // Kept apart from the drive counter so the timing check does not trust it
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            ver_run_ff <= '0;
        end else if (!in_mode || !verify_level) begin
            ver_run_ff <= '0;
        end else if (ver_run_ff != '1) begin
            ver_run_ff <= ver_run_ff + 6'h01;
        end
    end

    assign PROGRAM_DATA_PORT_OUT = data_ff;
    assign PROGRAM_DATA_PORT_OE = oe_ff;
    assign EPROM_ADDRESS = addr_ff;
    assign USER_MODE = (state_ff == eprom_pv_pkg::ST_USER);
    assign SIGNATURE_MODE = (state_ff == eprom_pv_pkg::ST_SIG);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    never_drive_program_pulse_strobe_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        program_pulse_strobe_level |-> ##1 !PROGRAM_DATA_PORT_OE) else $error("data port driven while programming");
    unknown_no_drive_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (state_ff == eprom_pv_pkg::ST_NONE) |-> !PROGRAM_DATA_PORT_OE) else $error("driven after bad code");
    verify_on_time_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (ver_run_ff >= 6'(VERIFY_DELAY - 1)) |-> PROGRAM_DATA_PORT_OE) else $error("verify data late");
    verify_not_early_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(PROGRAM_DATA_PORT_OE) |-> $past(in_mode && verify_level)) else $error("verify drive without mode");
    hi_latch_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        address_half_select_fall |=> (hi_addr_ff == $past(ADDRESS_INPUT_PORT[2:0]))) else $error("high part not latched");
    addr_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (!ADDRESS_HALF_SELECT && !lo_changed && !address_half_select_fall) [*2] |-> $stable(addr_ff) || settle_done)
        else $error("address moved while steady");
    addr_settle_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (!ADDRESS_HALF_SELECT && !lo_changed) [*8] ##1 (!ADDRESS_HALF_SELECT && !lo_changed) [*6]
        |=> (addr_ff == {hi_addr_ff, lo_seen_ff})) else $error("address not stable in time");
    user_code_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (state_ff == eprom_pv_pkg::ST_SHIFT && last_bit && code_full == eprom_pv_pkg::CODE_USER)
        |=> USER_MODE) else $error("user code not decoded");
    sig_code_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        $rose(SIGNATURE_MODE) |-> $past(code_full) == eprom_pv_pkg::CODE_SIGNATURE) else $error("bad signature entry");
    pre_high_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (state_ff == eprom_pv_pkg::ST_SHIFT) && $past(state_ff) == eprom_pv_pkg::ST_ARMED
        |-> $past(MODE_SERIAL_PIN, 2)) else $error("code began without pre-high");
endmodule : eprom_program_verify_port

/* File: tb/eprom_programmer.sv */
// Behavioural model of the external programming equipment.
// Assumes it shares the device clock and drives every pin just after a rising edge.
`timescale 1ns/1ps
module eprom_programmer (
    input wire logic clk, // Device clock
    output logic serial_pin, // Serial mode code line
    output logic addr_sel, // High part select strobe
    output logic [7:0] addr_port, // Multiplexed address
    output logic vpp_logic, // Supply pin logic level
    output logic vpp_high, // Programming voltage applied
    output logic program_pulse_strobe_strobe, // Program pulse strobe
    output logic [7:0] data_drv, // Byte driven on data port
    output logic data_drv_en // Data port driven by us
);
    // ----------------------------------------
    // Idle levels
    // ----------------------------------------
    // Strobe idles high so a pulse is a low then high
    initial begin
        serial_pin = 1'b0;
        addr_sel = 1'b0;
        addr_port = 8'h00;
        vpp_logic = 1'b1;
        vpp_high = 1'b0;
        program_pulse_strobe_strobe = 1'b1;
        data_drv = 8'h00;
        data_drv_en = 1'b0;
    end
    // code entry
    // High well past two machine cycles, then one bit a clock, LSB first, then low
    task automatic send_code(input logic [9:0] code);
        repeat (30) @(posedge clk);
        serial_pin <= 1'b1;
        repeat (30) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            serial_pin <= code[i];
            @(posedge clk);
        end
        serial_pin <= 1'b0;
    endtask : send_code
    // address multiplexing
    // Select held 14 clocks, high part held 3 clocks after the fall
    task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
        @(posedge clk);
        addr_sel <= 1'b1;
        addr_port <= hi;
        repeat (14) @(posedge clk);
        addr_sel <= 1'b0;
        repeat (3) @(posedge clk);
        addr_port <= lo;
    endtask : set_addr
    task automatic set_low(input logic [7:0] lo);
        @(posedge clk);
        addr_port <= lo;
    endtask : set_low
    // programming pulses
    // Data waits two clocks so the device has let go of the port
    task automatic program_byte(input logic [7:0] val, input int n);
        @(posedge clk);
        vpp_high <= 1'b1;
        repeat (2) @(posedge clk);
        data_drv <= val;
        data_drv_en <= 1'b1;
        repeat (n) begin
            repeat (3) @(posedge clk);
            program_pulse_strobe_strobe <= 1'b0;
            repeat (3) @(posedge clk);
            program_pulse_strobe_strobe <= 1'b1;
        end
        repeat (3) @(posedge clk);
    endtask : program_byte
    task automatic release_vpp();
        @(posedge clk);
        vpp_high <= 1'b0;
        data_drv_en <= 1'b0;
    endtask : release_vpp
endmodule : eprom_programmer

/* File: tb/eprom_program_verify_port_bench.sv */
// Self-checking bench for the EPROM program and verify port.
// Assumes the programmer model drives all pins but clock and reset; the bench drives those two and judges.
`timescale 1ns/1ps
module eprom_program_verify_port_bench;
    localparam logic [7:0] SIG0 = 8'h3c; // Arbitrary value
    localparam logic [7:0] SIG1 = 8'hc3; // Arbitrary value
    localparam int VD = eprom_pv_pkg::VERIFY_CLK;
    logic CLK_SYS = 1'b0;
    logic RESET = 1'b1;
    wire logic ser, sel, vlog, vhi, strb, oe, umode, smode, drv_en;
    wire logic [7:0] aport, drv, dout, data_wire;
    wire logic [10:0] addr;
    int n_errors = 0;
    int n_compared = 0;
    // Released port shows the inverse, never a stale match
    assign data_wire = oe ? dout : (drv_en ? drv : ~drv);
    // stand-in crystal clock
    // Only cycle counts matter here, so the fast period is harmless
    always #5 CLK_SYS = ~CLK_SYS;
    eprom_programmer program_pulse_strobe (.clk(CLK_SYS), .serial_pin(ser), .addr_sel(sel), .addr_port(aport),
        .vpp_logic(vlog), .vpp_high(vhi), .program_pulse_strobe_strobe(strb), .data_drv(drv), .data_drv_en(drv_en));
    eprom_program_verify_port #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1)) dut (.CLK_SYS(CLK_SYS), .RESET(RESET),
        .MODE_SERIAL_PIN(ser), .ADDRESS_HALF_SELECT(sel), .ADDRESS_INPUT_PORT(aport), .PORT0_BIT0_PIN(vlog),
        .PROGRAM_PULSE_STROBE_VOLTAGE_SENSE(vhi), .PORT0_BIT1_PIN(strb), .PROGRAM_DATA_PORT_IN(data_wire),
        .PROGRAM_DATA_PORT_OUT(dout), .PROGRAM_DATA_PORT_OE(oe), .EPROM_ADDRESS(addr),
        .USER_MODE(umode), .SIGNATURE_MODE(smode));
    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Old address must hold early, new one must land by 18 clocks
    task automatic addr_check(input logic [10:0] old_a, input logic [10:0] new_a);
        repeat (8) @(posedge CLK_SYS);
        #1 check(addr, old_a);
        repeat (10) @(posedge CLK_SYS);
        #1 check(addr, new_a);
    endtask : addr_check
    task automatic verify_read(input logic [7:0] exp);
        int k;
        // Voltage up first, so the delay is timed from its return
        program_pulse_strobe.program_byte(8'hff, 0);
        program_pulse_strobe.release_vpp();
        repeat (VD - 4) @(posedge CLK_SYS);
        #1 check({10'h000, oe}, 11'h000);
        k = 0;
        while (oe !== 1'b1 && k < 10) begin
            @(posedge CLK_SYS);
            #1 k++;
        end
        check({10'h000, oe}, 11'h001);
        check({3'h0, data_wire}, {3'h0, exp});
    endtask : verify_read
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_unknown();
        program_pulse_strobe.send_code(10'h284);
        repeat (3) @(posedge CLK_SYS);
        #1 check({9'h000, umode, smode}, 11'h000);
        repeat (VD + 10) @(posedge CLK_SYS);
        #1 check({10'h000, oe}, 11'h000);
    endtask : t_unknown
    task automatic t_signature();
        program_pulse_strobe.send_code(eprom_pv_pkg::CODE_SIGNATURE);
        repeat (2) @(posedge CLK_SYS);
        #1 check({9'h000, umode, smode}, 11'h001);
        program_pulse_strobe.set_addr(8'h00, 8'h30);
        addr_check(11'h000, eprom_pv_pkg::SIG_ADDR0);
        verify_read(SIG0);
        program_pulse_strobe.set_low(8'h31);
        addr_check(eprom_pv_pkg::SIG_ADDR0, eprom_pv_pkg::SIG_ADDR1);
        verify_read(SIG1);
    endtask : t_signature
    // Upper port bits of the high part must be dropped
    task automatic t_user();
        program_pulse_strobe.send_code(eprom_pv_pkg::CODE_USER);
        repeat (2) @(posedge CLK_SYS);
        #1 check({9'h000, umode, smode}, 11'h002);
        program_pulse_strobe.set_addr(8'hfd, 8'h3c);
        addr_check(eprom_pv_pkg::SIG_ADDR1, 11'h53c);
        program_pulse_strobe.program_byte(8'h00, eprom_pv_pkg::PULSES_PER_BYTE - 1);
        #1 check({10'h000, oe}, 11'h000);
        verify_read(eprom_pv_pkg::ERASED_BYTE);
        program_pulse_strobe.program_byte(8'ha5, eprom_pv_pkg::PULSES_PER_BYTE);
        verify_read(8'ha5);
        program_pulse_strobe.set_low(8'h3d);
        addr_check(11'h53c, 11'h53d);
        verify_read(eprom_pv_pkg::ERASED_BYTE);
        program_pulse_strobe.set_low(8'h3c);
        addr_check(11'h53d, 11'h53c);
        verify_read(8'ha5);
    endtask : t_user
    // ----------------------------------------
    // Run control
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    // Whole run is about a thousand clocks; this limit is thirty thousand
    initial begin
        #300000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (10) @(posedge CLK_SYS);
        RESET <= 1'b0;
        #1 check({oe, umode, smode, 8'h00}, 11'h000);
        check(addr, 11'h000);
        t_unknown();
        t_signature();
        t_user();
        tally_and_finish();
    end
endmodule : eprom_program_verify_port_bench
